// [rtl/dqrc_consts.vh]
`ifndef DQRC_CONSTS_VH
`define DQRC_CONSTS_VH
// ------------------------------------------------------------
// Reference level mode register fields
// ------------------------------------------------------------
`define DQRC_MR_ENABLE_BIT   7
`define DQRC_MR_RANGE_BIT    6
`define DQRC_MR_LEVEL_MSB    5
`define DQRC_MR_LEVEL_LSB    0
`define DQRC_MR_INDEX        3'h6
// Highest legal level code, 50 decimal
`define DQRC_LEVEL_MAX       6'h32
// Starting level near 75 percent of supply in range one
`define DQRC_LEVEL_START     6'h18
// ------------------------------------------------------------
// Command codes on the command port toward the sequencer
// ------------------------------------------------------------
`define DQRC_CMD_DES         3'h0
`define DQRC_CMD_MRS         3'h1
`define DQRC_CMD_ACT         3'h2
`define DQRC_CMD_WR          3'h3
`define DQRC_CMD_RD          3'h4
`define DQRC_CMD_PRE         3'h5
// ------------------------------------------------------------
// Timing figures in ns and the clock period in ps
// ------------------------------------------------------------
`define DQRC_CLK_PERIOD_PS   5000
`define DQRC_T_ENTRY_NS      150
`define DQRC_T_EXIT_NS       150
`define DQRC_T_SHORT_NS      150
`define DQRC_T_LONG_NS       250
// Least times round up to whole cycles
`define DQRC_CYC(ns)         (((ns) * 1000 + `DQRC_CLK_PERIOD_PS - 1) / `DQRC_CLK_PERIOD_PS)
`endif

// [rtl/dqrc_ctrl.v]
`timescale 1ns/1ps
`include "dqrc_consts.vh"
// Contract
// R1: Entry write sets enable, range, ignored level
// R2: Wait entry delay before calibration commands
// R3: Only traffic commands and level writes
// R4: Dummy writes allowed before first level
// R5: Level write keeps enable and range
// R6: Enable zero leaves range and level
// R7: Allow settling time after each level
// R8: Per-device mode allows only mode writes
// R9: Device keeps last level before exit
// R10: Exit only when all banks idle
// R11: Only deselect until exit delay elapsed
// R12: Recalibrate when temperature drifts much
// R13: Range set only by entry write
// R14: No new level in entry write
// R15: Settle last step before exit write
// R16: Final level write then exit write
// R17: Bits seven six are 10 or 11
// R18: Traffic per trial level records pass fail
// R19: Start level from drive and termination
// R20: Range bit picks range one or two
// R21: No default reference, program before use
// R22: Track mode and reuse entry range
module dqrc_ctrl #(
    parameter T_ENTRY = `DQRC_CYC(`DQRC_T_ENTRY_NS),
    parameter T_EXIT  = `DQRC_CYC(`DQRC_T_EXIT_NS),
    parameter T_SHORT = `DQRC_CYC(`DQRC_T_SHORT_NS),
    parameter T_LONG  = `DQRC_CYC(`DQRC_T_LONG_NS),
    parameter LONG_STEP = 4   // Step size above which the long settle applies
) (
    input  wire       CLK_I,
    input  wire       NRST_I,
    input  wire       START_I,        // Begin a calibration pass
    input  wire       RANGE_I,        // 0 range one, 1 range two
    input  wire [5:0] START_LEVEL_I,  // First trial code
    input  wire [5:0] LEVEL_STEP_I,   // Increment between trials
    input  wire       PDA_MODE_I,     // Per-device addressing active
    input  wire       BANKS_IDLE_I,   // All banks idle
    input  wire       TEST_DONE_I,    // Traffic burst for a trial finished
    input  wire       TEST_PASS_I,    // Result of that burst
    input  wire       CMD_READY_I,    // Command sequencer takes a command
    output reg        CMD_VALID_O,
    output reg  [2:0] CMD_O,
    output reg  [2:0] MR_ADDR_O,
    output reg  [7:0] MR_DATA_O,
    output reg        TEST_REQ_O,     // Run one traffic burst
    output reg        BUSY_O,
    output reg        CAL_ACTIVE_O,
    output reg        DONE_O,
    output reg        FAIL_O,
    output reg  [5:0] RESULT_O,
    output reg        RANGE_O
);
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam S_IDLE   = 4'h0;
    localparam S_ENTRY  = 4'h1;
    localparam S_EWAIT  = 4'h2;
    localparam S_DUMMY  = 4'h3;
    localparam S_SET    = 4'h4;
    localparam S_SETTLE = 4'h5;
    localparam S_TEST   = 4'h6;
    localparam S_FINAL  = 4'h7;
    localparam S_FSET   = 4'h8;
    localparam S_IDLEW  = 4'h9;
    localparam S_EXIT   = 4'ha;
    localparam S_XWAIT  = 4'hb;

    // ------------------------------------------------------------
    // Sequencer registers and derived values
    // ------------------------------------------------------------
    reg  [3:0] state;       // Sequencer state
    reg        range;       // Range chosen at entry
    reg  [5:0] level;       // Current trial code
    reg  [5:0] prev_level;  // Previously programmed code
    reg  [5:0] lo;          // First passing code
    reg  [5:0] hi;          // Last passing code
    reg        seen_pass;   // Any pass found
    reg        first_cal;   // First pass since reset
    reg        tload;       // Timer load strobe
    reg  [7:0] tcount;      // Timer load value
    wire       tdone;       // Timer elapsed
    wire [6:0] next_level;  // Next trial code, one bit wider
    wire [5:0] diff;        // Step size just programmed
    wire [6:0] mid_sum;     // Sum for eye centre

    // Step sum one bit wider so a step past the top code is seen
    // Step size picks short or long settle; centre is the mean of the edges
    assign next_level = {1'b0, level} + {1'b0, LEVEL_STEP_I};
    assign diff       = (level > prev_level) ? level - prev_level : prev_level - level;
    assign mid_sum    = {1'b0, lo} + {1'b0, hi};

    // ------------------------------------------------------------
    // Delay timer shared by all waits
    // ------------------------------------------------------------
    // One timer suffices since no two waits ever overlap
    dqrc_wait_timer #(.W(8)) u_timer (
        .clk_i   (CLK_I),
        .nrst_i  (NRST_I),
        .load_i  (tload),
        .count_i (tcount),
        .done_o  (tdone)
    );

    // ------------------------------------------------------------
    // Command handshake
    // ------------------------------------------------------------
    // Command counts as issued at the edge where both sides agree
    wire take = CMD_VALID_O && CMD_READY_I;

    // ------------------------------------------------------------
    // Main sequencer
    // ------------------------------------------------------------
    // Every output is a flop of this one process
    // Strobes default low each cycle; commands drop once taken
    // ------------------------------------------------------------
    always @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state        <= S_IDLE;
            range        <= 1'b0;
            level        <= 6'h00;
            prev_level   <= 6'h00;
            lo           <= 6'h00;
            hi           <= 6'h00;
            seen_pass    <= 1'b0;
            first_cal    <= 1'b1;
            tload        <= 1'b0;
            tcount       <= 8'h00;
            CMD_VALID_O  <= 1'b0;
            CMD_O        <= `DQRC_CMD_DES;
            MR_ADDR_O    <= 3'h0;
            MR_DATA_O    <= 8'h00;
            TEST_REQ_O   <= 1'b0;
            BUSY_O       <= 1'b0;
            CAL_ACTIVE_O <= 1'b0;
            DONE_O       <= 1'b0;
            FAIL_O       <= 1'b0;
            RESULT_O     <= 6'h00;
            RANGE_O      <= 1'b0;
        end else begin
            tload      <= 1'b0;
            TEST_REQ_O <= 1'b0;
            DONE_O     <= 1'b0;
            // Drop the offer after acceptance; a state may raise a new one
            if (take) begin
                CMD_VALID_O <= 1'b0;
                CMD_O       <= `DQRC_CMD_DES;
            end
            // Step through the calibration sequence
            case (state)
                S_IDLE: begin
                    // Start taken only when idle; caller repeats on drift R12
                    if (START_I) begin
                        range        <= RANGE_I;                       // R20 R22
                        level        <= START_LEVEL_I;                 // R19 R21
                        seen_pass    <= 1'b0;
                        BUSY_O       <= 1'b1;
                        FAIL_O       <= 1'b0;
                        CMD_VALID_O  <= 1'b1;
                        CMD_O        <= `DQRC_CMD_MRS;
                        MR_ADDR_O    <= `DQRC_MR_INDEX;
                        // Level field zero: no new level on entry R1 R14 R17
                        MR_DATA_O    <= {1'b1, RANGE_I, 6'h00};
                        state        <= S_ENTRY;
                    end
                end
                // Entry write outstanding until the sequencer takes it
                S_ENTRY: begin
                    if (take) begin
                        CAL_ACTIVE_O <= 1'b1;                          // R22
                        tload        <= 1'b1;
                        tcount       <= T_ENTRY[7:0];                  // R2
                        state        <= S_EWAIT;
                    end
                end
                S_EWAIT: begin
                    // Nothing but deselect during entry delay
                    if (tdone && !tload) begin                         // R2
                        if (first_cal && !PDA_MODE_I) begin
                            CMD_VALID_O <= 1'b1;
                            CMD_O       <= `DQRC_CMD_WR;               // R4
                            state       <= S_DUMMY;
                        end else begin
                            state <= S_SET;
                        end
                    end
                end
                // One dummy write after reset, before any level
                S_DUMMY: begin
                    if (take) begin
                        first_cal <= 1'b0;
                        state     <= S_SET;
                    end
                end
                // Offer the trial level once the bus is free
                S_SET: begin
                    if (!CMD_VALID_O) begin
                        CMD_VALID_O <= 1'b1;
                        CMD_O       <= `DQRC_CMD_MRS;
                        MR_ADDR_O   <= `DQRC_MR_INDEX;
                        MR_DATA_O   <= {1'b1, range, level};           // R5 R13 R17
                        state       <= S_SETTLE;
                    end
                end
                // Settle counted from acceptance, not from the offer
                S_SETTLE: begin
                    if (take) begin
                        tload      <= 1'b1;
                        // Long settle for large steps
                        tcount     <= (diff > LONG_STEP[5:0]) ? T_LONG[7:0] : T_SHORT[7:0]; // R7
                        prev_level <= level;
                        state      <= S_TEST;
                    end
                end
                S_TEST: begin
                    // Traffic only after settle; skipped in per-device mode R8
                    if (tdone && !tload) begin
                        if (PDA_MODE_I) begin
                            state <= S_FINAL;
                        end else if (!TEST_REQ_O) begin
                            TEST_REQ_O <= 1'b1;                        // R3 R18
                            state      <= S_FINAL;
                        end
                    end
                end
                // Record pass edges, then step or finish
                S_FINAL: begin
                    if (PDA_MODE_I || TEST_DONE_I) begin
                        if (TEST_PASS_I && !PDA_MODE_I) begin          // R18
                            if (!seen_pass) begin
                                lo <= level;
                            end
                            hi        <= level;
                            seen_pass <= 1'b1;
                        end
                        // Stop stepping past the top code or in per-device mode
                        if (!PDA_MODE_I && LEVEL_STEP_I != 6'h00 && next_level <= {1'b0, `DQRC_LEVEL_MAX}) begin
                            level <= next_level[5:0];
                            state <= S_SET;
                        end else begin
                            state <= S_FSET;
                        end
                    end
                end
                S_FSET: begin
                    // Final level write before exit R16
                    if (!CMD_VALID_O) begin
                        if (seen_pass) begin
                            level <= mid_sum[6:1];
                        end
                        CMD_VALID_O <= 1'b1;
                        CMD_O       <= `DQRC_CMD_MRS;
                        MR_ADDR_O   <= `DQRC_MR_INDEX;
                        MR_DATA_O   <= {1'b1, range, (seen_pass ? mid_sum[6:1] : level)}; // R16 R9
                        state       <= S_IDLEW;
                    end
                end
                // Final level settles fully; exit waits for idle banks
                S_IDLEW: begin
                    if (take) begin
                        tload      <= 1'b1;
                        // Long settle always: the centre may sit far from the last trial
                        tcount     <= T_LONG[7:0];                     // R15
                        prev_level <= level;
                    end else if (!CMD_VALID_O && tdone && !tload && BANKS_IDLE_I) begin // R10 R15
                        CMD_VALID_O <= 1'b1;
                        CMD_O       <= `DQRC_CMD_MRS;
                        MR_ADDR_O   <= `DQRC_MR_INDEX;
                        // Range kept in exit write; device ignores it R6 R13
                        MR_DATA_O   <= {1'b0, range, level};           // R16
                        state       <= S_EXIT;
                    end
                end
                // Mode counted as left once the exit write is taken
                S_EXIT: begin
                    if (take) begin
                        CAL_ACTIVE_O <= 1'b0;
                        tload        <= 1'b1;
                        tcount       <= T_EXIT[7:0];                   // R11
                        state        <= S_XWAIT;
                    end
                end
                // Only deselect while the exit delay runs
                S_XWAIT: begin
                    if (tdone && !tload) begin                         // R11
                        BUSY_O   <= 1'b0;
                        DONE_O   <= 1'b1;
                        FAIL_O   <= !seen_pass;
                        RESULT_O <= level;                             // R9
                        RANGE_O  <= range;
                        state    <= S_IDLE;
                    end
                end
                // Unused codes fall back to idle
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// [rtl/dqrc_wait_timer.v]
`timescale 1ns/1ps
`include "dqrc_consts.vh"
// ------------------------------------------------------------
// Down counter that reports when a loaded delay has elapsed
// ------------------------------------------------------------
module dqrc_wait_timer #(
    parameter W = 8
) (
    input  wire         clk_i,
    input  wire         nrst_i,
    input  wire         load_i,
    input  wire [W-1:0] count_i,
    output wire         done_o
);
    reg [W-1:0] remain;   // Cycles still to wait

    // Load wins over counting
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            remain <= {W{1'b0}};
        end else if (load_i) begin
            remain <= count_i;
        end else if (remain != {W{1'b0}}) begin
            remain <= remain - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign done_o = (remain == {W{1'b0}}) && !load_i;
endmodule

// [tb/dqrc_checker.sv]
`timescale 1ns/1ps
`include "dqrc_consts.vh"
// ------------------------------------------------------------
// Port watcher for the calibration controller
// ------------------------------------------------------------
module dqrc_checker (
    input wire       CLK_I,
    input wire       NRST_I,
    input wire       PDA_MODE_I,
    input wire       BANKS_IDLE_I,
    input wire       CMD_READY_I,
    input wire       CMD_VALID_O,
    input wire [2:0] CMD_O,
    input wire [2:0] MR_ADDR_O,
    input wire [7:0] MR_DATA_O,
    input wire       TEST_REQ_O,
    input wire       CAL_ACTIVE_O,
    input wire       DONE_O,
    input wire       RANGE_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    // Mode write on offer, and any accepted command
    wire mrs  = CMD_VALID_O && CMD_O == `DQRC_CMD_MRS;
    wire take = CMD_VALID_O && CMD_READY_I;
    reg  ent_range;   // Range bit of the last accepted entry write
    // Result port only updates at the end, so track the entry range here
    always @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ent_range <= 1'b0;
        end else if (take && mrs && !CAL_ACTIVE_O) begin
            ent_range <= MR_DATA_O[6];
        end
    end
    a_cmd_held: assert property (CMD_VALID_O && !CMD_READY_I |=>
        CMD_VALID_O && $stable(CMD_O) && $stable(MR_DATA_O)) else $error("command changed before acceptance");
    a_cmd_drop: assert property (take |=> !CMD_VALID_O) else $error("command not dropped after acceptance");
    a_mr_index: assert property (mrs |-> MR_ADDR_O == `DQRC_MR_INDEX) else $error("mode write to wrong register");
    a_entry_form: assert property (mrs && !CAL_ACTIVE_O |-> MR_DATA_O[7] && MR_DATA_O[5:0] == 6'h00)
        else $error("entry write malformed");
    a_keep_range: assert property (mrs && CAL_ACTIVE_O |-> MR_DATA_O[6] == ent_range)
        else $error("range bit changed in calibration");
    a_level_max: assert property (mrs && CAL_ACTIVE_O && MR_DATA_O[7] |-> MR_DATA_O[5:0] <= `DQRC_LEVEL_MAX)
        else $error("level code out of table");
    a_entry_wait: assert property (take && mrs && !CAL_ACTIVE_O |=> !CMD_VALID_O [*2])
        else $error("command inside entry delay");
    a_settle_wait: assert property (take && mrs && CAL_ACTIVE_O && MR_DATA_O[7] |=>
        (!TEST_REQ_O && !CMD_VALID_O) [*2]) else $error("no settling after level write");
    a_exit_idle: assert property (take && mrs && !MR_DATA_O[7] |-> BANKS_IDLE_I)
        else $error("exit write with banks busy");
    a_exit_quiet: assert property (take && mrs && !MR_DATA_O[7] |=> (!CMD_VALID_O && !DONE_O) [*2])
        else $error("activity inside exit delay");
    a_pda_only: assert property (PDA_MODE_I && (CMD_VALID_O || TEST_REQ_O) |-> mrs && !TEST_REQ_O)
        else $error("non mode command in per device mode");
    a_pulse_once: assert property (DONE_O || TEST_REQ_O |=> !DONE_O && !TEST_REQ_O)
        else $error("pulse output held");
    a_done_range: assert property (DONE_O |-> RANGE_O == ent_range && !CAL_ACTIVE_O)
        else $error("reported range differs from entry");
endmodule
bind dqrc_ctrl dqrc_checker chk (.CLK_I(CLK_I), .NRST_I(NRST_I), .PDA_MODE_I(PDA_MODE_I),
    .BANKS_IDLE_I(BANKS_IDLE_I), .CMD_READY_I(CMD_READY_I), .CMD_VALID_O(CMD_VALID_O), .CMD_O(CMD_O),
    .MR_ADDR_O(MR_ADDR_O), .MR_DATA_O(MR_DATA_O), .TEST_REQ_O(TEST_REQ_O), .CAL_ACTIVE_O(CAL_ACTIVE_O),
    .DONE_O(DONE_O), .RANGE_O(RANGE_O));

// [tb/dqrc_ctrl_tb.sv]
`timescale 1ns/1ps
`include "dqrc_consts.vh"
module dqrc_ctrl_tb;
    reg        clk, nrst, start, rng, per_device_addressing_mode, slow, hold;
    reg  [5:0] slvl, step, wlo, whi;
    wire       vld, rdy, treq, tdone, tpass, idle, busy, cal, done, fail, rng_o;
    wire [2:0] cmd, mra;
    wire [7:0] mrd;
    wire [5:0] res;
    integer    n_errors, compares, s_set, s_wr, s_oth, cyc;
    dqrc_ctrl #(.T_ENTRY(3), .T_EXIT(3), .T_SHORT(3), .T_LONG(4)) uut (.CLK_I(clk), .NRST_I(nrst),
        .START_I(start), .RANGE_I(rng), .START_LEVEL_I(slvl), .LEVEL_STEP_I(step), .PDA_MODE_I(per_device_addressing_mode),
        .BANKS_IDLE_I(idle), .TEST_DONE_I(tdone), .TEST_PASS_I(tpass), .CMD_READY_I(rdy), .CMD_VALID_O(vld),
        .CMD_O(cmd), .MR_ADDR_O(mra), .MR_DATA_O(mrd), .TEST_REQ_O(treq), .BUSY_O(busy), .CAL_ACTIVE_O(cal),
        .DONE_O(done), .FAIL_O(fail), .RESULT_O(res), .RANGE_O(rng_o));
    dqrc_dram_model dram (.clk_i(clk), .nrst_i(nrst), .cmd_valid_i(vld), .cmd_i(cmd), .mr_addr_i(mra),
        .mr_data_i(mrd), .test_req_i(treq), .slow_i(slow), .hold_i(hold), .win_lo_i(wlo), .win_hi_i(whi),
        .cmd_ready_o(rdy), .test_done_o(tdone), .test_pass_o(tpass), .banks_idle_o(idle));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task check(input [8*8-1:0] nm, input [7:0] e, input [7:0] g);
        begin
            compares = compares + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("[ERR] %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task conclude;
        begin
            $display("compares %0d mismatches %0d", compares, n_errors);
            if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // One pass; bank hold released after 200 cycles, bounded wait for done
    task run(input r, input [5:0] st, input [5:0] sp, input [5:0] lo, input [5:0] hi, input sl, input hd, input pm);
        begin
            s_set = dram.n_set; s_wr = dram.n_wr; s_oth = dram.n_other; cyc = 0;
            @(posedge clk);
            {rng, slvl, step, wlo, whi, slow, hold, per_device_addressing_mode, start} <= {r, st, sp, lo, hi, sl, hd, pm, 1'b1};
            @(posedge clk);
            start <= 1'b0;
            #1;
            check("busy", 8'h1, busy);
            while (done !== 1'b1 && cyc < 4000) begin
                @(posedge clk);
                cyc = cyc + 1;
                if (cyc == 200) hold <= 1'b0;
                #1;
            end
            if (cyc >= 4000) begin
                n_errors = n_errors + 1;
                $display("[ERR] done expected 1 seen 0");
                conclude;
            end
        end
    endtask
    task test_range_one;
        begin
            run(1'b0, 6'h14, 6'h02, 6'h18, 6'h1e, 1'b0, 1'b0, 1'b0);
            check("result", 8'h1b, res);
            check("fail", 8'h0, fail);
            check("dlevel", 8'h1b, dram.level);
            check("drange", 8'h0, dram.range);
            check("dcal", 8'h0, dram.cal_en);
            check("nset", 8'd17, dram.n_set - s_set);
            check("nwr", 8'd1, dram.n_wr);
            $display("test range_one done");
        end
    endtask
    task test_range_two;
        begin
            run(1'b1, 6'h2e, 6'h02, 6'h30, 6'h3f, 1'b1, 1'b0, 1'b0);
            check("result", 8'h31, res);
            check("range", 8'h1, rng_o);
            check("drange", 8'h1, dram.range);
            check("nbad", 8'h0, dram.n_bad);
            check("nset", 8'd4, dram.n_set - s_set);
            check("nwr", 8'd0, dram.n_wr - s_wr);
            $display("test range_two done");
        end
    endtask
    task test_no_pass;
        begin
            run(1'b0, 6'h00, 6'h08, 6'h3e, 6'h3f, 1'b1, 1'b1, 1'b0);
            check("fail", 8'h1, fail);
            check("result", 8'h30, res);
            check("dlevel", 8'h30, dram.level);
            check("late", 8'h1, cyc > 200);
            $display("test no_pass done");
        end
    endtask
    task test_pda;
        begin
            run(1'b0, 6'h10, 6'h00, 6'h00, 6'h3f, 1'b0, 1'b0, 1'b1);
            check("nother", 8'h0, dram.n_other - s_oth);
            check("nwr", 8'h0, dram.n_wr - s_wr);
            check("dcal", 8'h0, dram.cal_en);
            @(posedge clk);
            per_device_addressing_mode <= 1'b0;
            $display("test pda done");
        end
    endtask
    task test_mid_reset;
        begin
            @(posedge clk);
            start <= 1'b1;
            @(posedge clk);
            start <= 1'b0;
            repeat (20) @(posedge clk);
            nrst <= 1'b0;
            repeat (2) @(posedge clk);
            check("busy", 8'h0, busy);
            check("valid", 8'h0, vld);
            check("cal", 8'h0, cal);
            nrst <= 1'b1;
            run(1'b0, 6'h20, 6'h00, 6'h00, 6'h3f, 1'b0, 1'b0, 1'b0);
            check("result", 8'h20, res);
            check("nwr", 8'd1, dram.n_wr);
            $display("test mid_reset done");
        end
    endtask
    initial begin
        {nrst, start, rng, per_device_addressing_mode, slow, hold, slvl, step, wlo, whi} = 0;
        n_errors = 0;
        compares = 0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        check("valid", 8'h0, vld);
        check("cmd", 8'h0, cmd);
        test_range_one;
        test_range_two;
        test_no_pass;
        test_pda;
        test_mid_reset;
        conclude;
    end
endmodule

// [tb/dqrc_dram_model.sv]
`timescale 1ns/1ps
`include "dqrc_consts.vh"
// ------------------------------------------------------------
// Device side: sequencer, reference register, traffic result
// ------------------------------------------------------------
module dqrc_dram_model (
    input  wire       clk_i,
    input  wire       nrst_i,
    input  wire       cmd_valid_i,
    input  wire [2:0] cmd_i,
    input  wire [2:0] mr_addr_i,
    input  wire [7:0] mr_data_i,
    input  wire       test_req_i,
    input  wire       slow_i,
    input  wire       hold_i,
    input  wire [5:0] win_lo_i,
    input  wire [5:0] win_hi_i,
    output reg        cmd_ready_o,
    output reg        test_done_o,
    output reg        test_pass_o,
    output wire       banks_idle_o
);
    reg       cal_en;   // Calibration mode entered
    reg       range;    // Range fixed at entry
    reg [5:0] level;    // Operating level code
    reg [1:0] rdy_cnt;  // Slow mode grants every fourth cycle
    reg [2:0] burst;    // Traffic burst in flight
    integer   n_wr, n_other, n_bad, n_set;
    // Banks busy during traffic, or while the bench holds them
    assign banks_idle_o = burst == 3'h0 && !hold_i;
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {cal_en, range, level, rdy_cnt, burst} <= 0;
            {cmd_ready_o, test_done_o, test_pass_o} <= 3'h0;
            {n_wr, n_other, n_bad, n_set} <= 0;
        end else begin
            rdy_cnt     <= rdy_cnt + 2'h1;
            cmd_ready_o <= !slow_i || rdy_cnt == 2'h3;
            burst       <= test_req_i ? 3'h5 : burst - (burst != 3'h0);
            test_done_o <= burst == 3'h1;
            // Result judged on the level the device holds; junk outside the strobe
            test_pass_o <= (cal_en && level >= win_lo_i && level <= win_hi_i) ^ (burst != 3'h1);
            if (cmd_valid_i && cmd_ready_o) begin
                if (cmd_i == `DQRC_CMD_MRS && mr_addr_i == `DQRC_MR_INDEX) begin
                    if (mr_data_i[7] && !cal_en) begin
                        // Entry: level field ignored
                        cal_en <= 1'b1;
                        range  <= mr_data_i[6];
                    end else if (mr_data_i[7]) begin
                        level <= mr_data_i[5:0];
                        n_set <= n_set + 1;
                        if (mr_data_i[6] !== range) n_bad <= n_bad + 1;
                    end else begin
                        // Exit keeps range and level as they stand
                        cal_en <= 1'b0;
                    end
                end else if (cmd_i == `DQRC_CMD_WR) n_wr <= n_wr + 1;
                else if (cmd_i != `DQRC_CMD_DES) n_other <= n_other + 1;
            end
        end
    end
endmodule
